// >>> hdl/pcg_pkg.sv
// Package for the peripheral clock gate bank: offsets, layouts, types
package pcg_pkg;

   localparam int unsigned ADDR_W = 12;

   localparam logic [11:0] RUN_GATE_OFF = 12'h104;
   localparam logic [11:0] SLEEP_GATE_OFF = 12'h114;
   localparam logic [11:0] DEEP_GATE_OFF = 12'h124;
   localparam logic [11:0] RUN_CFG_OFF = 12'h200;
   localparam logic [11:0] IRQ_STATUS_OFF = 12'h300;
   localparam logic [11:0] IRQ_MASK_OFF = 12'h304;
   localparam logic [11:0] ACTIVE_OFF = 12'h308;

   localparam logic [31:0] GATE_RESET = 32'h0000_0000;
   localparam logic [31:0] GATE_MASK = 32'h0707_1133;
   localparam logic [31:0] RUN_CFG_RESET = 32'h0000_0000;
   localparam int unsigned AUTO_GATE_BIT = 27;
   localparam logic [31:0] RUN_CFG_MASK = 32'h0800_0000;
   localparam logic [31:0] IRQ_RESET = 32'h0000_0000;

   typedef struct packed {
      logic [4:0] rsvd_31_27;
      logic comparator_two_gate;
      logic comparator_one_gate;
      logic comparator_zero_gate;
      logic [4:0] rsvd_23_19;
      logic gp_counter_two_gate;
      logic gp_counter_one_gate;
      logic gp_counter_zero_gate;
      logic [2:0] rsvd_15_13;
      logic two_wire_zero_gate;
      logic [2:0] rsvd_11_9;
      logic encoder_zero_gate;
      logic [1:0] rsvd_7_6;
      logic sync_serial_one_gate;
      logic sync_serial_zero_gate;
      logic [1:0] rsvd_3_2;
      logic async_serial_one_gate;
      logic async_serial_zero_gate;
   } pcg_gate_t;

   typedef enum logic [1:0] {
      PCG_MODE_RUN = 2'b00,
      PCG_MODE_SLEEP = 2'b01,
      PCG_MODE_DEEP = 2'b10
   } pcg_mode_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } pcg_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pcg_apb_rsp_t;

endpackage

// >>> hdl/pcg_gate_bank.sv
// Peripheral clock gate bank with APB register slave
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps

// Operation
// - A set enable bit clocks its peripheral and a clear bit stops its clock.
// - An access to a peripheral whose clock is gated off is answered with a fault.
// - After reset every sleep-mode enable bit is zero and the register reads zero.
// - Enables come from the run, sleep or deep-sleep register by power mode.
// - The low-power registers apply only while the auto gating bit is set.
// - The sleep-mode gating register is a 32-bit word at offset 0x114.
// - Bits 26, 25 and 24 gate analog comparators 2, 1 and 0.
// - Bits 18, 17 and 16 gate general-purpose timers 2, 1 and 0.
// - Bit 12 gates two-wire serial unit 0.
// - Bit 8 gates quadrature encoder unit 0.
// - Bits 5 and 4 gate synchronous serial ports 1 and 0.
// - Bits 1 and 0 gate asynchronous serial units 1 and 0.
// - Reserved bits read as zero and software writes back what it read.
// - The run-mode gating register sits at 0x104 with the same bit layout.
module pcg_gate_bank (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pcg_pkg::pcg_apb_req_t apb_req_i,
   output pcg_pkg::pcg_apb_rsp_t apb_rsp_o,
   input wire logic sleep_i,
   input wire logic deep_sleep_i,
   input wire logic [31:0] periph_sel_i,
   output logic [31:0] periph_fault_o,
   output logic [31:0] periph_clk_o,
   output logic [31:0] periph_clk_en_o,
   output pcg_pkg::pcg_mode_t power_mode_o,
   output logic irq_o
);

   // Registers
   pcg_pkg::pcg_gate_t run_gate_reg;
   pcg_pkg::pcg_gate_t run_gate_next;
   pcg_pkg::pcg_gate_t sleep_gate_reg;
   pcg_pkg::pcg_gate_t sleep_gate_next;
   pcg_pkg::pcg_gate_t deep_gate_reg;
   pcg_pkg::pcg_gate_t deep_gate_next;
   logic [31:0] run_cfg_reg;
   logic [31:0] run_cfg_next;
   logic [31:0] irq_status_reg;
   logic [31:0] irq_status_next;
   logic [31:0] irq_mask_reg;
   logic [31:0] irq_mask_next;
   logic [31:0] active_reg;
   logic [31:0] active_next;
   logic [31:0] clk_en_low_reg;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   pcg_pkg::pcg_mode_t mode_reg;
   pcg_pkg::pcg_mode_t mode_next;

   // Decode wires
   wire logic setup_phase;
   wire logic access_phase;
   wire logic wr_access;
   wire logic hit_run;
   wire logic hit_sleep;
   wire logic hit_deep;
   wire logic hit_cfg;
   wire logic hit_status;
   wire logic hit_mask;
   wire logic hit_active;
   wire logic mapped;
   wire logic auto_gate;
   wire logic [31:0] wdata_gate;
   wire logic [31:0] fault_event;
   wire logic [31:0] status_clear;
   wire logic [31:0] read_mux;
   logic [31:0] selected;

   // Word match on a full aligned byte address
   function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
      addr_hit = (addr == off);
   endfunction

   // Masked replacement of a register on write
   function automatic logic [31:0] wr_merge(input logic [31:0] cur,
                                            input logic [31:0] data,
                                            input logic [31:0] mask,
                                            input logic hit);
      wr_merge = hit ? (data & mask) : cur;
   endfunction

   // Field-by-field copy; anything outside a named enable reads zero
   function automatic pcg_pkg::pcg_gate_t gate_fields(input logic [31:0] raw);
      pcg_pkg::pcg_gate_t src;
      src = raw;
      gate_fields = '0;
      gate_fields.comparator_two_gate = src.comparator_two_gate;
      gate_fields.comparator_one_gate = src.comparator_one_gate;
      gate_fields.comparator_zero_gate = src.comparator_zero_gate;
      gate_fields.gp_counter_two_gate = src.gp_counter_two_gate;
      gate_fields.gp_counter_one_gate = src.gp_counter_one_gate;
      gate_fields.gp_counter_zero_gate = src.gp_counter_zero_gate;
      gate_fields.two_wire_zero_gate = src.two_wire_zero_gate;
      gate_fields.encoder_zero_gate = src.encoder_zero_gate;
      gate_fields.sync_serial_one_gate = src.sync_serial_one_gate;
      gate_fields.sync_serial_zero_gate = src.sync_serial_zero_gate;
      gate_fields.async_serial_one_gate = src.async_serial_one_gate;
      gate_fields.async_serial_zero_gate = src.async_serial_zero_gate;
   endfunction

   assign setup_phase = apb_req_i.psel & ~apb_req_i.penable;
   assign access_phase = apb_req_i.psel & apb_req_i.penable;
   assign wr_access = access_phase & apb_req_i.pwrite;

   assign hit_sleep = addr_hit(apb_req_i.paddr, pcg_pkg::SLEEP_GATE_OFF);
   assign hit_run = addr_hit(apb_req_i.paddr, pcg_pkg::RUN_GATE_OFF);
   assign hit_deep = addr_hit(apb_req_i.paddr, pcg_pkg::DEEP_GATE_OFF);
   assign hit_cfg = addr_hit(apb_req_i.paddr, pcg_pkg::RUN_CFG_OFF);
   assign hit_status = addr_hit(apb_req_i.paddr, pcg_pkg::IRQ_STATUS_OFF);
   assign hit_mask = addr_hit(apb_req_i.paddr, pcg_pkg::IRQ_MASK_OFF);
   assign hit_active = addr_hit(apb_req_i.paddr, pcg_pkg::ACTIVE_OFF);

   assign mapped = hit_run | hit_sleep | hit_deep | hit_cfg |
                   hit_status | hit_mask | hit_active;

   assign wdata_gate = gate_fields(apb_req_i.pwdata);

   always_comb begin
      run_gate_next = wr_merge(run_gate_reg, wdata_gate, pcg_pkg::GATE_MASK,
                               wr_access & hit_run);
      sleep_gate_next = wr_merge(sleep_gate_reg, wdata_gate, pcg_pkg::GATE_MASK,
                                 wr_access & hit_sleep);
      deep_gate_next = wr_merge(deep_gate_reg, wdata_gate, pcg_pkg::GATE_MASK,
                                wr_access & hit_deep);
      run_cfg_next = wr_merge(run_cfg_reg, apb_req_i.pwdata, pcg_pkg::RUN_CFG_MASK,
                              wr_access & hit_cfg);
      irq_mask_next = wr_merge(irq_mask_reg, apb_req_i.pwdata, pcg_pkg::GATE_MASK,
                               wr_access & hit_mask);
   end

   assign auto_gate = run_cfg_reg[pcg_pkg::AUTO_GATE_BIT];

   // Power mode follows the processor; deep sleep outranks sleep
   always_comb begin
      if (deep_sleep_i) begin
         mode_next = pcg_pkg::PCG_MODE_DEEP;
      end else if (sleep_i) begin
         mode_next = pcg_pkg::PCG_MODE_SLEEP;
      end else begin
         mode_next = pcg_pkg::PCG_MODE_RUN;
      end
   end

   always_comb begin
      case (mode_reg)
         pcg_pkg::PCG_MODE_RUN: begin
            selected = run_gate_reg;
         end
         pcg_pkg::PCG_MODE_SLEEP: begin
            selected = auto_gate ? sleep_gate_reg : run_gate_reg;
         end
         pcg_pkg::PCG_MODE_DEEP: begin
            selected = auto_gate ? deep_gate_reg : run_gate_reg;
         end
         default: begin
            selected = run_gate_reg;
         end
      endcase
   end

   assign active_next = gate_fields(selected);

   assign fault_event = periph_sel_i & ~active_reg & pcg_pkg::GATE_MASK;
   assign periph_fault_o = fault_event;

   // One-to-clear write strobe for the status word
   assign status_clear = (wr_access & hit_status) ? apb_req_i.pwdata : 32'h0000_0000;

   // Set wins over the one-to-clear write
   assign irq_status_next = (irq_status_reg & ~status_clear) | fault_event;

   assign irq_o = |(irq_status_reg & irq_mask_reg);

   assign read_mux = hit_run ? run_gate_reg :
                     hit_sleep ? sleep_gate_reg :
                     hit_deep ? deep_gate_reg :
                     hit_cfg ? run_cfg_reg :
                     hit_status ? irq_status_reg :
                     hit_mask ? irq_mask_reg :
                     hit_active ? active_reg : 32'h0000_0000;

   // Read data sampled in setup so the access phase needs no wait
   assign prdata_next = (setup_phase & ~apb_req_i.pwrite) ? read_mux : prdata_reg;

   assign apb_rsp_o.prdata = prdata_reg;
   assign apb_rsp_o.pready = 1'b1;
   assign apb_rsp_o.pslverr = access_phase & ~mapped;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_gate_reg <= pcg_pkg::GATE_RESET;
      end else begin
         run_gate_reg <= run_gate_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sleep_gate_reg <= pcg_pkg::GATE_RESET;
      end else begin
         sleep_gate_reg <= sleep_gate_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         deep_gate_reg <= pcg_pkg::GATE_RESET;
      end else begin
         deep_gate_reg <= deep_gate_next;
      end
   end

   // Only the auto gating bit is kept
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_cfg_reg <= pcg_pkg::RUN_CFG_RESET;
      end else begin
         run_cfg_reg <= run_cfg_next;
      end
   end

   // Sticky events, cleared only by a one written
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status_reg <= pcg_pkg::IRQ_RESET;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   // Interrupt mask, same layout as the gates
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_reg <= pcg_pkg::IRQ_RESET;
      end else begin
         irq_mask_reg <= irq_mask_next;
      end
   end

   // Read word held until the next read setup
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prdata_reg <= 32'h0000_0000;
      end else begin
         prdata_reg <= prdata_next;
      end
   end

   // Core sleep levels share this clock, so no synchroniser
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg <= pcg_pkg::PCG_MODE_RUN;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // applied set changes only on an edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_reg <= pcg_pkg::GATE_RESET;
      end else begin
         active_reg <= active_next;
      end
   end

   // Enable retimed on the low phase so the AND gate cannot glitch
   always_ff @(negedge clk_i) begin
      if (rst_i) begin
         clk_en_low_reg <= pcg_pkg::GATE_RESET;
      end else begin
         clk_en_low_reg <= active_reg;
      end
   end

   assign periph_clk_o = {32{clk_i}} & clk_en_low_reg;
   assign periph_clk_en_o = active_reg;
   assign power_mode_o = mode_reg;

endmodule

// >>> bench/pcg_checker.sv
// Port checker for the clock gate bank
`timescale 1ns/100ps
module pcg_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pcg_pkg::pcg_apb_req_t apb_req_i,
   input wire pcg_pkg::pcg_apb_rsp_t apb_rsp_o,
   input wire logic sleep_i,
   input wire logic deep_sleep_i,
   input wire logic [31:0] periph_sel_i,
   input wire logic [31:0] periph_fault_o,
   input wire logic [31:0] periph_clk_o,
   input wire logic [31:0] periph_clk_en_o,
   input wire pcg_pkg::pcg_mode_t power_mode_o
);
   localparam logic [31:0] M = pcg_pkg::GATE_MASK;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire acc = apb_req_i.psel && apb_req_i.penable;
   wire [11:0] ad = apb_req_i.paddr;
   sequence run_wr;
      acc && apb_req_i.pwrite && ad == pcg_pkg::RUN_GATE_OFF;
   endsequence
   sequence in_run;
      power_mode_o == pcg_pkg::PCG_MODE_RUN;
   endsequence
   a_fault_gated: assert property (
      periph_fault_o == (periph_sel_i & ~periph_clk_en_o & M)) else $error("bad fault");
   a_en_reserved: assert property (
      (periph_clk_en_o & ~M) == 32'h0) else $error("bad enable");
   a_mode_track: assert property (
      1 |=> power_mode_o == ($past(deep_sleep_i) ? pcg_pkg::PCG_MODE_DEEP :
      $past(sleep_i) ? pcg_pkg::PCG_MODE_SLEEP : pcg_pkg::PCG_MODE_RUN)) else $error("bad mode");
   a_sleep_map: assert property (
      acc && ad == pcg_pkg::SLEEP_GATE_OFF |-> !apb_rsp_o.pslverr) else $error("bad map");
   a_run_map: assert property (
      acc && ad == pcg_pkg::RUN_GATE_OFF |-> !apb_rsp_o.pslverr) else $error("bad map");
   a_reserved_read: assert property (
      acc && !apb_req_i.pwrite && ad == pcg_pkg::SLEEP_GATE_OFF
      |-> (apb_rsp_o.prdata & ~M) == 32'h0) else $error("bad read");
   a_run_apply: assert property (
      run_wr ##1 in_run |=> periph_clk_en_o == ($past(apb_req_i.pwdata, 2) & M))
      else $error("bad apply");
   // Sampled on the low edge, where a gated clock shows its retimed enable
   a_clk_gate: assert property (@(negedge clk_i) disable iff (rst_i)
      periph_clk_o == ($past(periph_clk_en_o) & M)) else $error("bad clock");
endmodule

// >>> bench/pcg_periph_model.sv
// Gated peripheral side: access strobes and clock activity
`timescale 1ns/100ps
module pcg_periph_model (
   input wire logic clk_i,
   input wire logic clear_i,
   input wire logic [31:0] touch_i,
   input wire logic [31:0] periph_clk_i,
   output logic [31:0] periph_sel_o,
   output logic [31:0] alive_o
);
   // Strobe launched after the edge, like a bus decoder
   always_ff @(posedge clk_i) begin
      periph_sel_o <= touch_i;
   end
   for (genvar i = 0; i < 32; i++) begin : g_seen
      always @(posedge periph_clk_i[i] or posedge clear_i) begin
         alive_o[i] <= !clear_i;
      end
   end
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the clock gate bank
`timescale 1ns/100ps
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic sleep_i = 1'b0;
   logic deep_i = 1'b0;
   logic clr = 1'b0;
   logic [31:0] touch = 32'h0;
   logic [31:0] sel, fault, pclk, en, alive, r, msk;
   logic e, irq;
   pcg_pkg::pcg_apb_req_t req = '0;
   pcg_pkg::pcg_apb_rsp_t rsp;
   pcg_pkg::pcg_mode_t mode;
   int mismatches = 0;
   int n_compared = 0;
   int bits[12] = '{0, 1, 4, 5, 8, 12, 16, 17, 18, 24, 25, 26};
   always #50 clk_i = ~clk_i;
   pcg_gate_bank dut_u (.clk_i(clk_i), .rst_i(rst_i), .apb_req_i(req), .apb_rsp_o(rsp),
      .sleep_i(sleep_i), .deep_sleep_i(deep_i), .periph_sel_i(sel), .periph_fault_o(fault),
      .periph_clk_o(pclk), .periph_clk_en_o(en), .power_mode_o(mode), .irq_o(irq));
   pcg_periph_model peri_u (.clk_i(clk_i), .clear_i(clr), .touch_i(touch),
      .periph_clk_i(pclk), .periph_sel_o(sel), .alive_o(alive));
   task report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x) begin
         mismatches++;
         $display("Error at %0t: got %h want %h", $time, g, x);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_i);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (rsp.pready !== 1'b1) begin
         mismatches++;
         report_and_stop;
      end
      r = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r, x);
   endtask
   task settle;
      repeat (3) @(posedge clk_i);
   endtask
   task t_reset;
      rd(pcg_pkg::SLEEP_GATE_OFF, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk({31'h0, e}, 32'h1);
      $display("reset test done");
   endtask
   task t_map;
      msk = 32'h0;
      foreach (bits[k]) begin
         msk[bits[k]] = 1'b1;
      end
      wr(pcg_pkg::SLEEP_GATE_OFF, 32'hFFFF_FFFF);
      rd(pcg_pkg::SLEEP_GATE_OFF, msk);
      wr(pcg_pkg::RUN_GATE_OFF, 32'hFFFF_FFFF);
      rd(pcg_pkg::RUN_GATE_OFF, msk);
      $display("map test done");
   endtask
   task t_bits;
      foreach (bits[k]) begin
         wr(pcg_pkg::RUN_GATE_OFF, 32'h1 << bits[k]);
         clr <= 1'b1;
         @(posedge clk_i);
         clr <= 1'b0;
         touch <= msk;
         settle;
         chk(en, 32'h1 << bits[k]);
         chk(alive, 32'h1 << bits[k]);
         chk(fault, msk & ~(32'h1 << bits[k]));
         touch <= 32'h0;
      end
      $display("gate test done");
   endtask
   task t_irq;
      wr(pcg_pkg::IRQ_MASK_OFF, 32'h1);
      @(negedge clk_i);
      chk({31'h0, irq}, 32'h1);
      wr(pcg_pkg::IRQ_STATUS_OFF, 32'hFFFF_FFFF);
      rd(pcg_pkg::IRQ_STATUS_OFF, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(pcg_pkg::RUN_GATE_OFF, 32'h0);
      touch <= 32'h1;
      settle;
      touch <= 32'h0;
      chk({31'h0, irq}, 32'h1);
      wr(pcg_pkg::IRQ_MASK_OFF, 32'h0);
      @(negedge clk_i);
      chk({31'h0, irq}, 32'h0);
      wr(pcg_pkg::IRQ_STATUS_OFF, 32'h1);
      rd(pcg_pkg::IRQ_STATUS_OFF, 32'h0);
      $display("irq test done");
   endtask
   task t_modes;
      wr(pcg_pkg::SLEEP_GATE_OFF, 32'h10);
      wr(pcg_pkg::DEEP_GATE_OFF, 32'h20);
      wr(pcg_pkg::RUN_GATE_OFF, 32'h1);
      wr(pcg_pkg::RUN_CFG_OFF, 32'h0800_0000);
      sleep_i <= 1'b1;
      settle;
      chk(en, 32'h10);
      deep_i <= 1'b1;
      settle;
      chk(en, 32'h20);
      rd(pcg_pkg::ACTIVE_OFF, 32'h20);
      wr(pcg_pkg::RUN_CFG_OFF, 32'h0);
      settle;
      chk(en, 32'h1);
      sleep_i <= 1'b0;
      deep_i <= 1'b0;
      wr(pcg_pkg::SLEEP_GATE_OFF, 32'hFFFF_FFFF);
      rst_i <= 1'b1;
      settle;
      rst_i <= 1'b0;
      rd(pcg_pkg::SLEEP_GATE_OFF, 32'h0);
      chk(en, 32'h0);
      $display("mode test done");
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_map;
      t_bits;
      t_irq;
      t_modes;
      report_and_stop;
   end
endmodule
bind pcg_gate_bank pcg_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .apb_req_i(apb_req_i),
   .apb_rsp_o(apb_rsp_o), .sleep_i(sleep_i), .deep_sleep_i(deep_sleep_i),
   .periph_sel_i(periph_sel_i), .periph_fault_o(periph_fault_o), .periph_clk_o(periph_clk_o),
   .periph_clk_en_o(periph_clk_en_o), .power_mode_o(power_mode_o));
